// ==== src/cub_pkg.sv ====
// cub_pkg: constants and types shared by both ends of the current unbalance block
// assumes a single 250 MHz clock domain

package cub_pkg;

   // ---------------------------------------------------------------------------
   // widths and setting ranges
   // ---------------------------------------------------------------------------
   localparam int CUB_RMS_W = 16;
   localparam int CUB_PCT_W = 7;
   localparam int CUB_DLY_W = 16;
   localparam logic [CUB_PCT_W-1:0] CUB_START_PCT_MIN = 7'h0A;
   localparam logic [CUB_PCT_W-1:0] CUB_START_PCT_MAX = 7'h5A;
   localparam logic [CUB_PCT_W-1:0] CUB_START_PCT_RST = 7'h32;
   localparam logic [CUB_DLY_W-1:0] CUB_DELAY_MS_MIN = 16'h0064;
   localparam logic [CUB_DLY_W-1:0] CUB_DELAY_MS_MAX = 16'hEA60;
   localparam logic [CUB_DLY_W-1:0] CUB_DELAY_MS_RST = 16'h03E8;

   // ---------------------------------------------------------------------------
   // evaluation window on the largest current, percent of rated
   // ---------------------------------------------------------------------------
   localparam int CUB_LOW_PCT = 10;
   localparam int CUB_HIGH_PCT = 150;

   // ---------------------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------------------
   localparam int CUB_CLK_MHZ = 250;
   localparam int CUB_MS_NS = 1000000;
   localparam int CUB_CLK_NS = 4;
   localparam int CUB_CYC_PER_MS = CUB_MS_NS / CUB_CLK_NS;

   // ---------------------------------------------------------------------------
   // configuration port map
   // ---------------------------------------------------------------------------
   localparam logic [1:0] CUB_ADDR_CTRL = 2'h0;
   localparam logic [1:0] CUB_ADDR_START = 2'h1;
   localparam logic [1:0] CUB_ADDR_DELAY = 2'h2;
   localparam logic [1:0] CUB_ADDR_STAT = 2'h3;
   localparam int CUB_CTRL_OPER = 0;
   localparam int CUB_CTRL_SONLY = 1;
   localparam int CUB_CTRL_BLOCK = 2;

   typedef enum logic {CUB_IDLE, CUB_ARMED} cub_state_t;

endpackage : cub_pkg

// ==== src/cub_if.sv ====
// cub_if: the link between the unbalance function and its configuring logic
// assumes both ends share ref_clk_in

`timescale 1ns/1ns
`default_nettype none

interface cub_if;
   import cub_pkg::*;
   logic [CUB_RMS_W-1:0] phase1_fund_rms;
   logic [CUB_RMS_W-1:0] phase2_fund_rms;
   logic [CUB_RMS_W-1:0] phase3_fund_rms;
   logic [CUB_RMS_W-1:0] rated_current;
   logic operation_on;
   logic start_only;
   logic [CUB_PCT_W-1:0] start_pct;
   logic [CUB_DLY_W-1:0] delay_ms;
   logic unbalance_block_input;
   logic unbalance_general_start;
   logic unbalance_general_trip;
   logic start_event;
   logic trip_event;

   modport dev (
      input phase1_fund_rms, phase2_fund_rms, phase3_fund_rms, rated_current,
      input operation_on, start_only, start_pct, delay_ms, unbalance_block_input,
      output unbalance_general_start, unbalance_general_trip, start_event, trip_event
   );
   modport cfg (
      output phase1_fund_rms, phase2_fund_rms, phase3_fund_rms, rated_current,
      output operation_on, start_only, start_pct, delay_ms, unbalance_block_input,
      input unbalance_general_start, unbalance_general_trip, start_event, trip_event
   );
endinterface : cub_if

`default_nettype wire

// ==== src/cub_unbalance.sv ====
// cub_unbalance: decision logic of the current unbalance function
// assumes rms inputs and settings synchronous to ref_clk_in
// assumes the configuring end keeps settings inside their ranges
// outputs and event pulses come straight from flip-flops
// Notes on behaviour
// - pick largest and smallest phase current
// - flag when difference percent exceeds setting
// - start only with max in 10-150 % rated
// - operation off or block input suppresses all
// - trip after delay while start persists
// - start-only mode never trips
// - start setting 10..90 percent, default 50
// - delay 100..60000 ms from fault onset
// - user logic drives the block input
// - separate general start and trip outputs
// - event pulse on each start/trip edge
// - rms values supplied from upstream stage
//
// The strobed register port and the placing of the registers were decided locally.

`timescale 1ns/1ns
`default_nettype none

module cub_unbalance #(
   parameter int CYC_PER_MS = cub_pkg::CUB_CYC_PER_MS
) (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   cub_if.dev link
);
   import cub_pkg::*;

   // ---------------------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------------------
   // the prescaler needs at least one cycle per millisecond
   if (CYC_PER_MS < 1) begin : g_cyc_low
      $error("CYC_PER_MS must be at least 1");
   end
   // a threshold of 100 percent or more could never be exceeded
   if (CUB_START_PCT_MAX >= 7'h64) begin : g_pct_high
      $error("start threshold range must stay below 100 percent");
   end
   // window factors must fit the eight extra bits of the products
   if (CUB_LOW_PCT < 1 || CUB_HIGH_PCT > 32'h0000_00FF) begin : g_win_range
      $error("evaluation window factors must lie in 1 to 255");
   end
   if (CUB_LOW_PCT >= CUB_HIGH_PCT) begin : g_win_empty
      $error("evaluation window is empty");
   end
   // a zero delay would trip in the same cycle as start
   if (CUB_DELAY_MS_MIN < 16'h0001) begin : g_dly_zero
      $error("shortest trip delay must be at least 1 ms");
   end

   // ---------------------------------------------------------------------------
   // constants
   // ---------------------------------------------------------------------------
   // percent scale of the cross-multiplied compares
   localparam logic [7:0] PCT_FULL = 8'h64;
   localparam logic [7:0] PCT_LOW = 8'(CUB_LOW_PCT);
   localparam logic [7:0] PCT_HIGH = 8'(CUB_HIGH_PCT);

   // ---------------------------------------------------------------------------
   // state
   // ---------------------------------------------------------------------------
   typedef struct packed {
      cub_state_t state;
      logic [31:0] cyc_cnt;
      logic [CUB_DLY_W-1:0] ms_cnt;
      logic start;
      logic trip;
      logic start_ev;
      logic trip_ev;
   } cub_dev_t;

   cub_dev_t s_r;
   cub_dev_t s_nxt;

   function automatic logic [CUB_RMS_W-1:0] max3(input logic [CUB_RMS_W-1:0] a,
      input logic [CUB_RMS_W-1:0] b, input logic [CUB_RMS_W-1:0] c);
      logic [CUB_RMS_W-1:0] m;
      m = (a > b) ? a : b;
      return (m > c) ? m : c;
   endfunction : max3

   function automatic logic [CUB_RMS_W-1:0] min3(input logic [CUB_RMS_W-1:0] a,
      input logic [CUB_RMS_W-1:0] b, input logic [CUB_RMS_W-1:0] c);
      logic [CUB_RMS_W-1:0] m;
      m = (a < b) ? a : b;
      return (m < c) ? m : c;
   endfunction : min3

   // widened before multiplying, so 150 percent of full scale cannot wrap
   function automatic logic [CUB_RMS_W+7:0] pct_of(input logic [CUB_RMS_W-1:0] v,
      input logic [7:0] p);
      return (CUB_RMS_W+8)'(v) * (CUB_RMS_W+8)'(p);
   endfunction : pct_of

   // ---------------------------------------------------------------------------
   // analogue conditions
   // ---------------------------------------------------------------------------
   logic [CUB_RMS_W-1:0] i_max;
   logic [CUB_RMS_W-1:0] i_min;
   logic [CUB_RMS_W-1:0] i_diff;
   logic [CUB_RMS_W+7:0] diff_x100;
   logic [CUB_RMS_W+7:0] max_x_pct;
   logic [CUB_RMS_W+7:0] max_x100;
   logic [CUB_RMS_W+7:0] rated_lo;
   logic [CUB_RMS_W+7:0] rated_hi;
   logic unbal_cond;
   logic max_current_sufficient;
   logic max_current_not_fault;
   logic fault_state;

   always_comb begin
      i_max = max3(link.phase1_fund_rms, link.phase2_fund_rms, link.phase3_fund_rms);
      i_min = min3(link.phase1_fund_rms, link.phase2_fund_rms, link.phase3_fund_rms);
      i_diff = i_max - i_min;
      // cross-multiplied to avoid a divider: diff*100 > max*pct
      diff_x100 = pct_of(i_diff, PCT_FULL);
      max_x_pct = pct_of(i_max, 8'(link.start_pct));
      unbal_cond = diff_x100 > max_x_pct;
      max_x100 = pct_of(i_max, PCT_FULL);
      rated_lo = pct_of(link.rated_current, PCT_LOW);
      rated_hi = pct_of(link.rated_current, PCT_HIGH);
      // both window ends are strict, a current right on a bound is outside
      max_current_sufficient = max_x100 > rated_lo;
      max_current_not_fault = max_x100 < rated_hi;
      fault_state = link.operation_on && !link.unbalance_block_input
         && unbal_cond && max_current_sufficient && max_current_not_fault;
   end

   // ---------------------------------------------------------------------------
   // millisecond prescaler
   // ---------------------------------------------------------------------------
   logic ms_tick;
   logic ms_full;

   // the count is one at onset, so a tick falls every CYC_PER_MS cycles
   assign ms_tick = s_r.cyc_cnt >= 32'(CYC_PER_MS);
   // saturate rather than wrap, so a long start cannot drop the trip
   assign ms_full = s_r.ms_cnt == {CUB_DLY_W{1'b1}};

   // ---------------------------------------------------------------------------
   // decision and delay
   // ---------------------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.start_ev = 1'b0;
      s_nxt.trip_ev = 1'b0;
      if (!fault_state) begin
         // any lost precondition drops start and rewinds the timer
         s_nxt.state = CUB_IDLE;
         s_nxt.cyc_cnt = '0;
         s_nxt.ms_cnt = '0;
         s_nxt.start = 1'b0;
         s_nxt.trip = 1'b0;
      end else begin
         // start follows the fault one cycle late; the timer runs from onset
         s_nxt.start = 1'b1;
         unique case (s_r.state)
            CUB_IDLE: begin
               s_nxt.state = CUB_ARMED;
               s_nxt.cyc_cnt = 32'h0000_0001;
               s_nxt.ms_cnt = '0;
            end
            CUB_ARMED: begin
               // timer counts from fault onset, so decision latency is inside it
               if (ms_tick) begin
                  s_nxt.cyc_cnt = 32'h0000_0001;
                  if (!ms_full) begin
                     s_nxt.ms_cnt = s_r.ms_cnt + 16'h0001;
                  end
               end else begin
                  s_nxt.cyc_cnt = s_r.cyc_cnt + 32'h0000_0001;
               end
            end
         endcase
         // start-only mode holds trip low whatever the elapsed time
         s_nxt.trip = !link.start_only && (s_nxt.ms_cnt >= link.delay_ms);
      end
      // one pulse per edge of start or trip, in the cycle the output moves
      s_nxt.start_ev = s_nxt.start != s_r.start;
      s_nxt.trip_ev = s_nxt.trip != s_r.trip;
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s_r <= '{
            state: CUB_IDLE,
            cyc_cnt: 32'h0000_0000,
            ms_cnt: '0,
            start: 1'b0,
            trip: 1'b0,
            start_ev: 1'b0,
            trip_ev: 1'b0
         };
      end else begin
         s_r <= s_nxt;
      end
   end

   // ---------------------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------------------
   assign link.unbalance_general_start = s_r.start;
   assign link.unbalance_general_trip = s_r.trip;
   assign link.start_event = s_r.start_ev;
   assign link.trip_event = s_r.trip_ev;

endmodule : cub_unbalance

`default_nettype wire

// ==== src/cub_config.sv ====
// cub_config: configuring end, software registers, interrupt and input drive
// assumes a plain one-cycle register port from software and upstream rms values

`timescale 1ns/1ns
`default_nettype none

module cub_config (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic [1:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   output logic irq_out,
   input wire logic [cub_pkg::CUB_RMS_W-1:0] phase1_fund_rms_in,
   input wire logic [cub_pkg::CUB_RMS_W-1:0] phase2_fund_rms_in,
   input wire logic [cub_pkg::CUB_RMS_W-1:0] phase3_fund_rms_in,
   input wire logic [cub_pkg::CUB_RMS_W-1:0] rated_current_in,
   input wire logic user_block_in,
   cub_if.cfg link
);
   import cub_pkg::*;

   // ---------------------------------------------------------------------------
   // state
   // ---------------------------------------------------------------------------
   typedef struct packed {
      logic oper;
      logic sonly;
      logic [CUB_PCT_W-1:0] pct;
      logic [CUB_DLY_W-1:0] dly;
      logic [3:0] stat;
      logic [3:0] mask;
      logic [31:0] rdata;
   } cub_cfg_t;

   cub_cfg_t s_r;
   cub_cfg_t s_nxt;

   function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
      input logic [31:0] hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clamp

   // ---------------------------------------------------------------------------
   // register port; status bits: start on, start off, trip on, trip off
   // ---------------------------------------------------------------------------
   logic [3:0] ev;
   logic [31:0] c;

   always_comb begin
      s_nxt = s_r;
      c = '0;
      ev = {link.trip_event & ~link.unbalance_general_trip,
            link.trip_event & link.unbalance_general_trip,
            link.start_event & ~link.unbalance_general_start,
            link.start_event & link.unbalance_general_start};
      s_nxt.rdata = '0;
      if (wr_in) begin
         unique case (addr_in)
            CUB_ADDR_CTRL: begin
               s_nxt.oper = wdata_in[CUB_CTRL_OPER];
               s_nxt.sonly = wdata_in[CUB_CTRL_SONLY];
               s_nxt.mask = wdata_in[11:8];
            end
            CUB_ADDR_START: begin
               // out-of-range settings are clamped, never passed on
               c = clamp(wdata_in, 32'(CUB_START_PCT_MIN), 32'(CUB_START_PCT_MAX));
               s_nxt.pct = c[CUB_PCT_W-1:0];
            end
            CUB_ADDR_DELAY: begin
               c = clamp(wdata_in, 32'(CUB_DELAY_MS_MIN), 32'(CUB_DELAY_MS_MAX));
               s_nxt.dly = c[CUB_DLY_W-1:0];
            end
            CUB_ADDR_STAT: s_nxt.stat = s_r.stat & ~wdata_in[3:0];
         endcase
      end
      s_nxt.stat = s_nxt.stat | ev; // set wins over clear
      if (rd_in) begin
         unique case (addr_in)
            CUB_ADDR_CTRL: s_nxt.rdata = {20'h0_0000, s_r.mask, 5'h00,
               user_block_in, s_r.sonly, s_r.oper};
            CUB_ADDR_START: s_nxt.rdata = 32'(s_r.pct);
            CUB_ADDR_DELAY: s_nxt.rdata = 32'(s_r.dly);
            CUB_ADDR_STAT: s_nxt.rdata = {22'h00_0000, link.unbalance_general_trip,
               link.unbalance_general_start, 4'h0, s_r.stat};
         endcase
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s_r <= '{oper: 1'b0, sonly: 1'b0, pct: CUB_START_PCT_RST, dly: CUB_DELAY_MS_RST,
                  stat: 4'h0, mask: 4'h0, rdata: 32'h0000_0000};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdata_out = s_r.rdata;
   assign irq_out = |(s_r.stat & s_r.mask);
   assign link.operation_on = s_r.oper;
   assign link.start_only = s_r.sonly;
   assign link.start_pct = s_r.pct;
   assign link.delay_ms = s_r.dly;
   assign link.unbalance_block_input = user_block_in;
   assign link.phase1_fund_rms = phase1_fund_rms_in;
   assign link.phase2_fund_rms = phase2_fund_rms_in;
   assign link.phase3_fund_rms = phase3_fund_rms_in;
   assign link.rated_current = rated_current_in;

endmodule : cub_config

`default_nettype wire

// ==== test/cub_unbalance_assertions.sv ====
// cub_unbalance_chk: assertions on the link between the two ends
// assumes one clock domain, signals taken straight from cub_if
`timescale 1ns/1ns
`default_nettype none
module cub_unbalance_chk import cub_pkg::*; #(
   parameter int CYC_PER_MS = 2
) (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic [CUB_RMS_W-1:0] phase1_fund_rms,
   input wire logic [CUB_RMS_W-1:0] phase2_fund_rms,
   input wire logic [CUB_RMS_W-1:0] phase3_fund_rms,
   input wire logic [CUB_RMS_W-1:0] rated_current,
   input wire logic operation_on,
   input wire logic start_only,
   input wire logic [CUB_PCT_W-1:0] start_pct,
   input wire logic [CUB_DLY_W-1:0] delay_ms,
   input wire logic unbalance_block_input,
   input wire logic unbalance_general_start,
   input wire logic unbalance_general_trip,
   input wire logic start_event,
   input wire logic trip_event
);
   logic [CUB_RMS_W-1:0] mx, mn;
   logic [31:0] run_r, due;
   logic st, tr, fault;
   assign st = unbalance_general_start;
   assign tr = unbalance_general_trip;
   assign due = 32'(delay_ms) * CYC_PER_MS;
   always_comb begin
      mx = phase1_fund_rms > phase2_fund_rms ? phase1_fund_rms : phase2_fund_rms;
      mx = mx > phase3_fund_rms ? mx : phase3_fund_rms;
      mn = phase1_fund_rms < phase2_fund_rms ? phase1_fund_rms : phase2_fund_rms;
      mn = mn < phase3_fund_rms ? mn : phase3_fund_rms;
   end
   // strict compares at both window ends and at the threshold
   assign fault = operation_on && !unbalance_block_input
      && 32'(mx - mn) * 100 > 32'(mx) * start_pct
      && 32'(mx) * 100 > 32'(rated_current) * CUB_LOW_PCT
      && 32'(mx) * 100 < 32'(rated_current) * CUB_HIGH_PCT;
   // cycles the start output has been standing
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         run_r <= 32'h0000_0000;
      end else begin
         run_r <= st ? run_r + 1 : 32'h0000_0000;
      end
   end
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);
   start_on_a: assert property (fault |=> st) else $error("start missing");
   start_off_a: assert property (!fault |=> !st) else $error("start stuck");
   oper_off_a: assert property (!operation_on || unbalance_block_input |=> !st && !tr)
      else $error("output while disabled");
   start_only_a: assert property (start_only |=> !tr) else $error("trip in start-only");
   trip_hold_a: assert property (tr |-> st) else $error("trip without start");
   trip_early_a: assert property ($rose(tr) |-> run_r + 2 >= due) else $error("trip early");
   trip_late_a: assert property (st && !tr && !start_only && !$past(start_only)
      |-> run_r <= due + 1) else $error("trip late");
   start_evt_a: assert property ($changed(st) == start_event) else $error("start event");
   trip_evt_a: assert property ($changed(tr) == trip_event) else $error("trip event");
   cover property ($rose(st));
   cover property ($rose(tr));
   cover property (st && start_only);
endmodule : cub_unbalance_chk
`default_nettype wire

// ==== test/cub_unbalance_tb.sv ====
// cub_unbalance_tb: both ends joined, software port driven by tasks
// assumes CYC_PER_MS shortened to 2 so 100 ms is 200 cycles
`timescale 1ns/1ns
`default_nettype none
module cub_unbalance_tb;
   import cub_pkg::*;
   localparam int CYC = 2;
   logic ref_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [1:0] addr_in = 2'h0;
   logic [31:0] wdata_in = 32'h0000_0000;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic blk = 1'b0;
   logic [31:0] rdata_out;
   logic irq_out;
   logic [15:0] p1 = 16'h0000, p2 = 16'h0000, p3 = 16'h0000, rated = 16'h03E8;
   int err_count = 0, checks = 0, n;
   // {phase1, phase2, phase3, expected start}
   logic [15:0] tab [8][4] = '{'{16'h03E8, 16'h03E8, 16'h01F4, 16'h0000},
      '{16'h03E8, 16'h03E8, 16'h01F3, 16'h0001}, '{16'h01F3, 16'h03E8, 16'h03E8, 16'h0001},
      '{16'h03E8, 16'h0190, 16'h03E8, 16'h0001}, '{16'h05DC, 16'h05DC, 16'h0064, 16'h0000},
      '{16'h05DB, 16'h05DB, 16'h0064, 16'h0001}, '{16'h0064, 16'h0064, 16'h000A, 16'h0000},
      '{16'h0065, 16'h0065, 16'h000A, 16'h0001}};
   cub_if lnk();
   cub_unbalance #(.CYC_PER_MS(CYC)) u_cub_unbalance (.ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in), .link(lnk));
   cub_config u_cub_config (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .irq_out(irq_out), .phase1_fund_rms_in(p1), .phase2_fund_rms_in(p2),
      .phase3_fund_rms_in(p3), .rated_current_in(rated), .user_block_in(blk), .link(lnk));
   cub_unbalance_chk #(.CYC_PER_MS(CYC)) u_cub_unbalance_chk (.ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in), .phase1_fund_rms(lnk.phase1_fund_rms),
      .phase2_fund_rms(lnk.phase2_fund_rms), .phase3_fund_rms(lnk.phase3_fund_rms),
      .rated_current(lnk.rated_current), .operation_on(lnk.operation_on),
      .start_only(lnk.start_only), .start_pct(lnk.start_pct), .delay_ms(lnk.delay_ms),
      .unbalance_block_input(lnk.unbalance_block_input),
      .unbalance_general_start(lnk.unbalance_general_start),
      .unbalance_general_trip(lnk.unbalance_general_trip),
      .start_event(lnk.start_event), .trip_event(lnk.trip_event));
   always #2 ref_clk_in = ~ref_clk_in;
   // --------
   // tasks
   // --------
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_reg
   task automatic chk_pin(input logic got, input logic exp);
      chk_reg({31'h0000_0000, got}, {31'h0000_0000, exp});
   endtask : chk_pin
   task automatic wr(input logic [1:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge ref_clk_in);
      wr_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [1:0] a, input logic [31:0] e);
      @(posedge ref_clk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge ref_clk_in);
      rd_in <= 1'b0;
      #1;
      chk_reg(rdata_out, e);
   endtask : rd
   task automatic inj(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
      @(posedge ref_clk_in);
      p1 <= a;
      p2 <= b;
      p3 <= c;
   endtask : inj
   task automatic wt(input int k);
      repeat (k) @(posedge ref_clk_in);
      #1;
   endtask : wt
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test
   // --------
   // sequence
   // --------
   initial begin
      repeat (6) @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      rd(CUB_ADDR_CTRL, 32'h0000_0000);
      rd(CUB_ADDR_START, 32'h0000_0032);
      rd(CUB_ADDR_DELAY, 32'h0000_03E8);
      rd(CUB_ADDR_STAT, 32'h0000_0000);
      wr(CUB_ADDR_START, 32'h0000_0005);
      rd(CUB_ADDR_START, 32'h0000_000A);
      wr(CUB_ADDR_START, 32'h0000_005B);
      rd(CUB_ADDR_START, 32'h0000_005A);
      wr(CUB_ADDR_DELAY, 32'h0000_EA61);
      rd(CUB_ADDR_DELAY, 32'h0000_EA60);
      wr(CUB_ADDR_DELAY, 32'h0000_0063);
      rd(CUB_ADDR_DELAY, 32'h0000_0064);
      wr(CUB_ADDR_START, 32'h0000_0032);
      $display("test settings done");
      inj(16'h03E8, 16'h03E8, 16'h0190);
      wt(4);
      chk_pin(lnk.unbalance_general_start, 1'b0);
      inj(16'h03E8, 16'h03E8, 16'h03E8);
      wr(CUB_ADDR_CTRL, 32'h0000_0001);
      for (int i = 0; i < 8; i++) begin
         inj(tab[i][0], tab[i][1], tab[i][2]);
         wt(2);
         chk_pin(lnk.unbalance_general_start, tab[i][3][0]);
         inj(16'h03E8, 16'h03E8, 16'h03E8);
         wt(2);
      end
      @(posedge ref_clk_in);
      rated <= 16'h07D0;
      inj(16'h05DC, 16'h05DC, 16'h0064);
      wt(2);
      chk_pin(lnk.unbalance_general_start, 1'b1);
      inj(16'h03E8, 16'h03E8, 16'h03E8);
      wt(2);
      @(posedge ref_clk_in);
      rated <= 16'h03E8;
      wr(CUB_ADDR_STAT, 32'h0000_000F);
      $display("test thresholds done");
      inj(16'h03E8, 16'h03E8, 16'h0190);
      for (n = 0; n < 400 && lnk.unbalance_general_trip !== 1'b1; n++) wt(1);
      if (n >= 400) err_count++;
      if (n >= 400) end_of_test();
      chk_pin(n >= 200 && n <= 203, 1'b1);
      rd(CUB_ADDR_STAT, 32'h0000_0305);
      chk_pin(irq_out, 1'b0);
      wr(CUB_ADDR_CTRL, 32'h0000_0F01);
      wt(1);
      chk_pin(irq_out, 1'b1);
      inj(16'h03E8, 16'h03E8, 16'h03E8);
      wt(2);
      chk_pin(lnk.unbalance_general_trip, 1'b0);
      rd(CUB_ADDR_STAT, 32'h0000_000F);
      wr(CUB_ADDR_STAT, 32'h0000_000F);
      rd(CUB_ADDR_STAT, 32'h0000_0000);
      chk_pin(irq_out, 1'b0);
      $display("test trip done");
      wr(CUB_ADDR_CTRL, 32'h0000_0003);
      inj(16'h03E8, 16'h03E8, 16'h0190);
      wt(260);
      chk_pin(lnk.unbalance_general_start, 1'b1);
      chk_pin(lnk.unbalance_general_trip, 1'b0);
      $display("test start only done");
      @(posedge ref_clk_in);
      blk <= 1'b1;
      rd(CUB_ADDR_CTRL, 32'h0000_0007);
      wt(2);
      chk_pin(lnk.unbalance_general_start, 1'b0);
      $display("test block done");
      end_of_test();
   end
endmodule : cub_unbalance_tb
`default_nettype wire
